//--- dv/compare_match_timer_8bit_tb.sv
// Purpose: Self-checking bench for the compare-match timer.
// Assumes: Slave may insert wait states; byte address is four times the register index.
// Notes: Expected counts come from the pulse counts the bench itself sends.
`timescale 1ns/1ps
`default_nettype none

module compare_match_timer_8bit_tb;
	localparam logic [15:0] CC = match_timer_pkg::IDX_CLOCK_CLEAR;
	localparam logic [15:0] FL = match_timer_pkg::IDX_FLAGS;
	localparam logic [15:0] CA = match_timer_pkg::IDX_CONST_A;
	localparam logic [15:0] CB = match_timer_pkg::IDX_CONST_B;
	localparam logic [15:0] CN = match_timer_pkg::IDX_COUNTER;
	localparam logic [15:0] TR = match_timer_pkg::IDX_TRIGGER;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic low_power = 1'b0;
	logic [31:0] rdata;
	logic [7:0] rst_vals [6] = '{8'h00, 8'h10, 8'hff, 8'hff, 8'h00, 8'he2};
	wire logic hreadyout;
	wire logic hresp;
	wire logic [31:0] hrdata;
	wire logic wave_out;
	wire logic match_a_irq;
	wire logic match_b_irq;
	wire logic overflow_irq;
	wire logic ext_clk_in;
	wire logic ext_reset_in;
	wire logic trigger_in;
	int error_cnt = 0;
	int check_count = 0;
	int cycles = 0;

	always #4 clock = ~clock;

	compare_match_timer_8bit compare_match_timer_8bit_inst (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .low_power(low_power), .ext_clk_in(ext_clk_in),
		.ext_reset_in(ext_reset_in), .trigger_in(trigger_in), .wave_out(wave_out), .match_a_irq(match_a_irq),
		.match_b_irq(match_b_irq), .overflow_irq(overflow_irq));

	pin_source pin_source_inst (.clock(clock), .ext_clk_in(ext_clk_in), .ext_reset_in(ext_reset_in),
		.trigger_in(trigger_in));

	task automatic tally_and_finish();
		if (error_cnt == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// The master holds each phase until it samples hready high; no wait count is assumed.
	task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {14'h0, idx, 2'h0};
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge clock); while (hreadyout !== 1'b1);
		rdata = hrdata;
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
		bus(1'b1, idx, wd);
	endtask

	task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		chk32(rdata, {24'h0, exp});
	endtask

	task automatic wave_step(input logic [7:0] fl, input logic exp);
		wr(FL, fl);
		wr(CN, 8'h01);
		pin_source_inst.pulse(0, 1);
		chk1(wave_out, exp);
	endtask

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			rd(CC + 16'(i), rst_vals[i]);
		end
		rd(16'hffbe, 8'h00);
		wr(CN, 8'h5a);
		rd(CN, 8'h5a);
		// Codes 100 to 111: off, rising, falling, both edges, two pulses each.
		for (int m = 4; m < 8; m++) begin
			wr(CC, 8'(m));
			wr(CN, 8'h00);
			pin_source_inst.pulse(0, 2);
			rd(CN, (m == 4) ? 8'h00 : (m == 7) ? 8'h04 : 8'h02);
		end
		// Internal taps divide by four then eight; read latency allows a small spread.
		wr(CC, 8'h01);
		for (int k = 0; k < 2; k++) begin
			wr(TR, 8'(k));
			wr(CN, 8'h00);
			repeat (64) @(posedge clock);
			bus(1'b0, CN, 8'h00);
			chk1((rdata >= 32'(15 >> k)) && (rdata <= 32'(18 >> k)), 1'b1);
		end
		wr(CA, 8'h03);
		wr(CB, 8'h40);
		wr(CC, 8'h25);
		wr(CN, 8'hff);
		pin_source_inst.pulse(0, 1);
		rd(CN, 8'h00);
		chk1(overflow_irq, 1'b1);
		wr(FL, 8'h00);
		rd(FL, 8'h30);
		wr(FL, 8'h00);
		rd(FL, 8'h10);
		wr(FL, 8'he0);
		rd(FL, 8'h10);
		chk1(overflow_irq, 1'b0);
		// Clear on match A with a toggling output, then counting goes on.
		wr(FL, 8'h03);
		wr(CC, 8'h0d);
		wr(CN, 8'h00);
		pin_source_inst.pulse(0, 3);
		rd(CN, 8'h00);
		chk1(wave_out, 1'b1);
		rd(FL, 8'h53);
		chk1(match_a_irq, 1'b0);
		wr(CC, 8'h4d);
		@(negedge clock);
		chk1(match_a_irq, 1'b1);
		pin_source_inst.pulse(0, 1);
		rd(CN, 8'h01);
		wr(CC, 8'h15);
		wr(CN, 8'h3e);
		pin_source_inst.pulse(0, 2);
		rd(CN, 8'h00);
		wr(CC, 8'h1d);
		wr(CN, 8'h20);
		pin_source_inst.pulse(1, 1);
		rd(CN, 8'h00);
		// Trigger start and halt on clear.
		wr(CC, 8'h0d);
		wr(TR, 8'h0c);
		pin_source_inst.pulse(0, 1);
		rd(CN, 8'h00);
		pin_source_inst.pulse(2, 1);
		pin_source_inst.pulse(0, 3);
		pin_source_inst.pulse(0, 1);
		rd(CN, 8'h00);
		pin_source_inst.pulse(2, 1);
		pin_source_inst.pulse(0, 1);
		rd(CN, 8'h01);
		wr(CC, 8'h05);
		for (int c = 0; c < 4; c++) begin
			wr(TR, 8'h00);
			wr(TR, 8'h04 | 8'(c << 3));
			pin_source_inst.pulse(2, 1);
			pin_source_inst.pulse(0, 1);
			rd(CN, 8'(c + 1));
		end
		wr(TR, 8'h00);
		wr(CA, 8'h02);
		wr(CB, 8'h02);
		wave_step(8'h02, 1'b1);
		wave_step(8'h0e, 1'b0);
		wave_step(8'h09, 1'b1);
		low_power <= 1'b1;
		repeat (4) @(posedge clock);
		low_power <= 1'b0;
		rd(CN, 8'h00);
		rd(CC, 8'h00);
		rd(CA, 8'hff);
		rd(CB, 8'hff);
		tally_and_finish();
	end
endmodule

`default_nettype wire

//--- dv/pin_source.sv
// Purpose: Far-side pin sources for the compare-match timer.
// Assumes: Pins change just after a rising system clock edge.
// Notes: Each level stands four cycles, so a three-flop synchroniser sees every edge.
`timescale 1ns/1ps
`default_nettype none

module pin_source (
	input wire logic clock,
	output logic ext_clk_in,
	output logic ext_reset_in,
	output logic trigger_in
);
	logic [2:0] pins_reg = 3'h0;

	assign ext_clk_in = pins_reg[0];
	assign ext_reset_in = pins_reg[1];
	assign trigger_in = pins_reg[2];

	// Pin 0 is the clock, 1 the counter clear, 2 the trigger; a pulse is one rise and one fall.
	task automatic pulse(input int pin, input int n);
		repeat (n) begin
			@(posedge clock);
			pins_reg[pin] <= 1'b1;
			repeat (4) @(posedge clock);
			pins_reg[pin] <= 1'b0;
			repeat (4) @(posedge clock);
		end
		repeat (4) @(posedge clock);
	endtask
endmodule

`default_nettype wire

//--- hdl/compare_match_timer_8bit.sv
// Purpose: 8-bit compare-match timer with an AHB-Lite register slave.
// Assumes: External pins are asynchronous and slow against the 125 MHz clock.
// Notes: low_power forces the power-down initial values while it is high.
//
// Contract
// - Counter counts selected clock, CPU reads/writes anytime.
// - Wrap from ff to 00 sets overflow_flag.
// - Reset and low power zero counter, clock_clear_ctrl.
// - Reset and low power set constants to ff.
// - Constants compared always except during their write.
// - Each flag with its enable raises its request.
// - Clear select: none, match A, match B, external.
// - With trigger_en, clearing halts until trigger edge.
// - Without trigger_en, counting continues after clear.
// - Clock select picks off or internal divider pair.
// - Internal divided clock counts on falling edge.
// - External clock: off, rising, falling or both.
// - wave_out follows compare matches per output select.
// - Flags accept only zero writes, never set.
// - Trigger edge rising, falling or both starts counting.
// - Simultaneous matches: toggle over one over zero.
// - Setting trigger_en stops counter until trigger edge.
// - Trigger edge code: off, rise, fall, both.
// - Flag clears only after read as one.
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module compare_match_timer_8bit #(
	parameter int PRESCALE_WIDTH = 7
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic low_power,
	input wire logic ext_clk_in,
	input wire logic ext_reset_in,
	input wire logic trigger_in,
	output logic wave_out,
	output logic match_a_irq,
	output logic match_b_irq,
	output logic overflow_irq
);

	if (PRESCALE_WIDTH < match_timer_pkg::MIN_PRESCALE_WIDTH) begin : g_bad_width
		$error("PRESCALE_WIDTH too small for the slowest tap.");
	end

	function automatic logic addr_hit(input logic [31:0] addr, input logic [15:0] idx);
		addr_hit = (addr[31:2] == {14'h0000, idx});
	endfunction

	function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
		edge_hit = (sel[0] & rise) | (sel[1] & fall);
	endfunction

	function automatic logic wave_resolve(input logic [1:0] act_a, input logic [1:0] act_b, input logic cur);
		if (act_a == match_timer_pkg::ACT_TOGGLE || act_b == match_timer_pkg::ACT_TOGGLE) begin
			wave_resolve = ~cur;
		end else if (act_a == match_timer_pkg::ACT_ONE || act_b == match_timer_pkg::ACT_ONE) begin
			wave_resolve = 1'b1;
		end else if (act_a == match_timer_pkg::ACT_ZERO || act_b == match_timer_pkg::ACT_ZERO) begin
			wave_resolve = 1'b0;
		end else begin
			wave_resolve = cur;
		end
	endfunction

	// Bus phase state. Select order: clock_clear, flags, const_a, const_b, counter, trigger.
	logic ph_write_reg;
	logic [5:0] ph_sel_reg;
	logic [31:0] hrdata_reg;

	// Block state.
	logic [7:0] clock_clear_reg, trigger_reg, const_a_reg, const_b_reg, cnt_reg;
	logic [3:0] os_reg;
	logic [2:0] flag_reg, armed_reg;
	logic run_reg, eq_a_prev_reg, eq_b_prev_reg, wave_reg;
	logic irq_a_reg, irq_b_reg, irq_ovf_reg;
	logic [PRESCALE_WIDTH-1:0] pre_reg, pre_prev_reg;
	logic [2:0] sync1_reg, sync2_reg, sync3_reg;

	// Address phase decode.
	wire addr_take = hsel & htrans[1] & hready;
	wire [5:0] addr_sel = {addr_hit(haddr, match_timer_pkg::IDX_TRIGGER),
		addr_hit(haddr, match_timer_pkg::IDX_COUNTER),
		addr_hit(haddr, match_timer_pkg::IDX_CONST_B),
		addr_hit(haddr, match_timer_pkg::IDX_CONST_A),
		addr_hit(haddr, match_timer_pkg::IDX_FLAGS),
		addr_hit(haddr, match_timer_pkg::IDX_CLOCK_CLEAR)};
	wire [5:0] rd_sel = addr_sel & {6{addr_take & ~hwrite}};
	wire [5:0] wr_sel = ph_sel_reg & {6{ph_write_reg}};
	wire [7:0] wdata = hwdata[7:0];

	// Control fields.
	wire [2:0] clk_sel = clock_clear_reg[match_timer_pkg::CC_CLK_LO +: 3];
	wire [1:0] clear_sel = clock_clear_reg[match_timer_pkg::CC_CLEAR_LO +: 2];
	wire [2:0] irq_en = {clock_clear_reg[match_timer_pkg::CC_MATCH_B_IE],
		clock_clear_reg[match_timer_pkg::CC_MATCH_A_IE], clock_clear_reg[match_timer_pkg::CC_OVF_IE]};
	wire trigger_en = trigger_reg[match_timer_pkg::TC_TRIG_EN];
	wire [1:0] trig_edge = trigger_reg[match_timer_pkg::TC_EDGE_LO +: 2];
	wire int_clk_sel0 = trigger_reg[match_timer_pkg::TC_INT_CLK];

	// Edges are taken between the second and third stages only.
	wire [2:0] pin_rise = sync2_reg & ~sync3_reg;
	wire [2:0] pin_fall = ~sync2_reg & sync3_reg;
	wire ext_rst_rise = pin_rise[1];
	wire trig_evt = edge_hit(trig_edge, pin_rise[2], pin_fall[2]);

	// Taps 1 to 6 give the divide-by-4 to divide-by-128 clocks.
	wire [2:0] tap_idx = {clk_sel[1:0], int_clk_sel0} - 3'h1;
	wire tap_fall = pre_prev_reg[tap_idx] & ~pre_reg[tap_idx];
	wire int_tick = (clk_sel[1:0] != 2'h0) & tap_fall;
	wire ext_tick = edge_hit(clk_sel[1:0], pin_rise[0], pin_fall[0]);
	wire tick = clk_sel[2] ? ext_tick : int_tick;

	// A halted counter only runs while trigger_en is clear or a trigger has come.
	wire counting = ~trigger_en | run_reg;
	wire cnt_adv = tick & counting;

	// Compare is masked in the data phase of a write to the constant.
	wire eq_a = (cnt_reg == const_a_reg) & ~wr_sel[2];
	wire eq_b = (cnt_reg == const_b_reg) & ~wr_sel[3];
	wire mp_a = eq_a & ~eq_a_prev_reg;
	wire mp_b = eq_b & ~eq_b_prev_reg;

	wire cnt_clear = (clear_sel == match_timer_pkg::CLR_MATCH_A & mp_a) |
		(clear_sel == match_timer_pkg::CLR_MATCH_B & mp_b) |
		(clear_sel == match_timer_pkg::CLR_EXT & ext_rst_rise);
	wire ovf_evt = cnt_adv & (cnt_reg == 8'hff) & ~cnt_clear & ~wr_sel[4];

	// CPU write wins over clear, clear wins over counting.
	wire [7:0] cnt_step = cnt_adv ? cnt_reg + 8'h01 : cnt_reg;
	wire [7:0] cnt_next = low_power ? match_timer_pkg::RST_COUNTER :
		wr_sel[4] ? wdata : cnt_clear ? 8'h00 : cnt_step;

	// Halt at clear while trigger_en is set or when trigger_en is newly set; a trigger edge restarts.
	wire halt_now = (cnt_clear & trigger_en) | (wr_sel[5] & wdata[match_timer_pkg::TC_TRIG_EN] & ~trigger_en);
	wire run_next = low_power ? 1'b0 : trig_evt ? 1'b1 : halt_now ? 1'b0 : run_reg;

	wire [7:0] clock_clear_next = low_power ? match_timer_pkg::RST_CLOCK_CLEAR :
		wr_sel[0] ? wdata : clock_clear_reg;
	wire [7:0] trigger_next = low_power ? match_timer_pkg::RST_TRIGGER :
		wr_sel[5] ? (wdata | match_timer_pkg::TRIGGER_RESERVED_MASK) : trigger_reg;
	wire [7:0] const_a_next = low_power ? match_timer_pkg::RST_CONST : wr_sel[2] ? wdata : const_a_reg;
	wire [7:0] const_b_next = low_power ? match_timer_pkg::RST_CONST : wr_sel[3] ? wdata : const_b_reg;
	wire [3:0] os_next = low_power ? match_timer_pkg::RST_FLAGS[3:0] : wr_sel[1] ? wdata[3:0] : os_reg;

	// Flags: only zero writes to armed bits clear, and a set in the same cycle wins.
	wire [2:0] flag_set = {mp_b, mp_a, ovf_evt};
	wire [2:0] flag_clr = {3{wr_sel[1]}} & ~wdata[match_timer_pkg::FL_OVF +: 3] & armed_reg;
	wire [2:0] flag_next = low_power ? 3'h0 : flag_set | (flag_reg & ~flag_clr);
	wire [2:0] armed_next = ((armed_reg & ~flag_clr) | (rd_sel[1] ? flag_next : 3'h0)) & flag_next;

	wire [1:0] act_a = mp_a ? os_reg[match_timer_pkg::FL_OUT_A_LO +: 2] : match_timer_pkg::ACT_KEEP;
	wire [1:0] act_b = mp_b ? os_reg[match_timer_pkg::FL_OUT_B_LO +: 2] : match_timer_pkg::ACT_KEEP;
	wire wave_next = wave_resolve(act_a, act_b, wave_reg);

	// Reads use next values so a write in the data phase before is seen.
	wire [7:0] flags_view = {flag_next, 1'b0, os_next} | match_timer_pkg::FLAGS_RESERVED_MASK;
	wire [7:0] rd_byte = ({8{addr_sel[0]}} & clock_clear_next) | ({8{addr_sel[1]}} & flags_view) |
		({8{addr_sel[2]}} & const_a_next) | ({8{addr_sel[3]}} & const_b_next) |
		({8{addr_sel[4]}} & cnt_next) | ({8{addr_sel[5]}} & trigger_next);
	wire [31:0] hrdata_next = (rd_sel != 6'h00) ? {24'h000000, rd_byte} : 32'h00000000;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ph_write_reg <= 1'b0;
			ph_sel_reg <= 6'h00;
			hrdata_reg <= 32'h00000000;
			hreadyout <= 1'b0;
		end else begin
			ph_write_reg <= addr_take & hwrite;
			ph_sel_reg <= addr_take ? addr_sel : 6'h00;
			hrdata_reg <= hrdata_next;
			hreadyout <= 1'b1;
		end
	end

	// Three stages; the first is read only by the second.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
			sync3_reg <= 3'h0;
			pre_reg <= '0;
			pre_prev_reg <= '0;
		end else begin
			sync1_reg <= {trigger_in, ext_reset_in, ext_clk_in};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			pre_reg <= pre_reg + 1'b1;
			pre_prev_reg <= pre_reg;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			clock_clear_reg <= match_timer_pkg::RST_CLOCK_CLEAR;
			trigger_reg <= match_timer_pkg::RST_TRIGGER;
			const_a_reg <= match_timer_pkg::RST_CONST;
			const_b_reg <= match_timer_pkg::RST_CONST;
			cnt_reg <= match_timer_pkg::RST_COUNTER;
			os_reg <= match_timer_pkg::RST_FLAGS[3:0];
			flag_reg <= 3'h0;
			armed_reg <= 3'h0;
			run_reg <= 1'b0;
		end else begin
			clock_clear_reg <= clock_clear_next;
			trigger_reg <= trigger_next;
			const_a_reg <= const_a_next;
			const_b_reg <= const_b_next;
			cnt_reg <= cnt_next;
			os_reg <= os_next;
			flag_reg <= flag_next;
			armed_reg <= armed_next;
			run_reg <= run_next;
		end
	end

	// Requests are registered from next state so they track flag and enable in the same cycle.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			eq_a_prev_reg <= 1'b0;
			eq_b_prev_reg <= 1'b0;
			wave_reg <= 1'b0;
			irq_a_reg <= 1'b0;
			irq_b_reg <= 1'b0;
			irq_ovf_reg <= 1'b0;
		end else begin
			eq_a_prev_reg <= eq_a;
			eq_b_prev_reg <= eq_b;
			wave_reg <= wave_next;
			irq_b_reg <= flag_next[2] & clock_clear_next[match_timer_pkg::CC_MATCH_B_IE];
			irq_a_reg <= flag_next[1] & clock_clear_next[match_timer_pkg::CC_MATCH_A_IE];
			irq_ovf_reg <= flag_next[0] & clock_clear_next[match_timer_pkg::CC_OVF_IE];
		end
	end

	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign wave_out = wave_reg;
	assign match_a_irq = irq_a_reg;
	assign match_b_irq = irq_b_reg;
	assign overflow_irq = irq_ovf_reg;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	sequence s_count_step;
		cnt_adv && !cnt_clear && !wr_sel[4] && !low_power;
	endsequence

	sequence s_clear_halt;
		mp_a && clear_sel == match_timer_pkg::CLR_MATCH_A && trigger_en && !trig_evt && !wr_sel[4] && !low_power;
	endsequence

	sequence s_held;
		trigger_en && !run_reg && !trig_evt && !cnt_clear && !wr_sel[4] && !low_power;
	endsequence

	a_count_step: assert property (s_count_step |=> cnt_reg == $past(cnt_reg) + 8'h01)
		else $error("Counter did not advance by one.");
	a_overflow_set: assert property ((s_count_step ##0 cnt_reg == 8'hff) |=> flag_reg[0] && cnt_reg == 8'h00)
		else $error("Wrap did not set overflow_flag.");
	a_lowpower_init: assert property (low_power |=> cnt_reg == 8'h00 && clock_clear_reg == 8'h00 &&
		const_a_reg == 8'hff && const_b_reg == 8'hff)
		else $error("Low power did not initialise registers.");
	a_match_a_flag: assert property ((mp_a && !low_power) |=> flag_reg[1])
		else $error("Match A did not set its flag.");
	a_const_mask: assert property (wr_sel[2] |-> !mp_a)
		else $error("Compare A active during constant write.");
	a_irq_gate: assert property (match_a_irq == (flag_reg[1] && clock_clear_reg[match_timer_pkg::CC_MATCH_A_IE]))
		else $error("Match A request disagrees with flag and enable.");
	a_clear_halt: assert property (s_clear_halt |=> cnt_reg == 8'h00 && !run_reg ##1 s_held)
		else $error("Clear with trigger_en did not halt the counter.");
	a_halt_hold: assert property (s_held |=> cnt_reg == $past(cnt_reg))
		else $error("Halted counter moved.");
	a_trig_start: assert property ((trig_evt && !low_power) |=> run_reg)
		else $error("Trigger edge did not start counting.");
	a_no_sw_set: assert property ((wr_sel[1] && wdata[7] && !flag_reg[2] && !mp_b) |=> !flag_reg[2])
		else $error("Software set match_flag_b.");
	a_clear_needs_read: assert property ((wr_sel[1] && !wdata[6] && flag_reg[1] && !armed_reg[1] && !low_power)
		|=> flag_reg[1])
		else $error("Flag cleared without a prior read.");
	a_wave_toggle: assert property ((mp_a && os_reg[1:0] == match_timer_pkg::ACT_TOGGLE) |=> wave_out != $past(wave_out))
		else $error("Toggle on match A lost.");
	// The slave only becomes ready on the first edge after reset, so that edge is skipped.
	a_bus_okay: assert property (!$past(rst) |-> hreadyout && !hresp)
		else $error("Slave not ready or not OKAY.");

	a_match_b_flag: assert property ((mp_b && !low_power)
		|=> flag_reg[2])
		else $error("Match B did not set its flag.");

	a_ovf_irq_gate: assert property (overflow_irq ==
		(flag_reg[0] && clock_clear_reg[match_timer_pkg::CC_OVF_IE]))
		else $error("Overflow request disagrees with flag and enable.");

	a_b_irq_gate: assert property (match_b_irq ==
		(flag_reg[2] && clock_clear_reg[match_timer_pkg::CC_MATCH_B_IE]))
		else $error("Match B request disagrees with flag and enable.");

	a_clear_on_b: assert property ((clear_sel == match_timer_pkg::CLR_MATCH_B && mp_b && !wr_sel[4] && !low_power)
		|=> cnt_reg == 8'h00)
		else $error("Match B did not clear the counter.");

	a_clear_on_pin: assert property ((clear_sel == match_timer_pkg::CLR_EXT && ext_rst_rise && !wr_sel[4] && !low_power)
		|=> cnt_reg == 8'h00)
		else $error("External clear edge did not clear the counter.");

	a_free_after_clear: assert property ((cnt_clear && !trigger_en && !wr_sel[4] && !wr_sel[5] && !low_power)
		|=> counting)
		else $error("Counter stopped after clear without trigger_en.");

	a_clock_off: assert property ((clk_sel[1:0] == 2'h0 && !wr_sel[4] && !cnt_clear && !low_power)
		|=> cnt_reg == $past(cnt_reg))
		else $error("Counter moved with clocking disabled.");

	a_int_fall: assert property ((clk_sel == 3'h1 && !int_clk_sel0 && pre_prev_reg[1] && !pre_reg[1] && counting &&
		!wr_sel[4] && !cnt_clear && !low_power) |=> cnt_reg == $past(cnt_reg) + 8'h01)
		else $error("Divide-by-four falling edge did not count.");

	a_ext_rise: assert property ((clk_sel == 3'h5 && pin_rise[0] && counting && !wr_sel[4] && !cnt_clear && !low_power)
		|=> cnt_reg == $past(cnt_reg) + 8'h01)
		else $error("External rising edge did not count.");

	a_ext_rise_only: assert property ((clk_sel == 3'h5 && !pin_rise[0] && !wr_sel[4] && !cnt_clear && !low_power)
		|=> cnt_reg == $past(cnt_reg))
		else $error("Counter moved without a rising edge.");

	a_ext_both: assert property ((clk_sel == 3'h7 && pin_fall[0] && counting && !wr_sel[4] && !cnt_clear && !low_power)
		|=> cnt_reg == $past(cnt_reg) + 8'h01)
		else $error("Falling edge not counted in both-edge mode.");

	a_wave_one: assert property ((mp_a && os_reg[1:0] == match_timer_pkg::ACT_ONE &&
		!(mp_b && os_reg[3:2] == match_timer_pkg::ACT_TOGGLE)) |=> wave_out)
		else $error("Drive one on match A lost.");

	a_wave_zero: assert property ((mp_a && os_reg[1:0] == match_timer_pkg::ACT_ZERO && !mp_b)
		|=> !wave_out)
		else $error("Drive zero on match A lost.");

	a_wave_keep: assert property ((!mp_a && !mp_b)
		|=> wave_out == $past(wave_out))
		else $error("Output changed without a compare match.");

	a_wave_prio: assert property ((mp_a && mp_b && os_reg[3:2] == match_timer_pkg::ACT_ONE &&
		os_reg[1:0] == match_timer_pkg::ACT_ZERO) |=> wave_out)
		else $error("Drive one did not win over drive zero.");

	a_flag_hold: assert property ((flag_reg[1] && !wr_sel[1] && !low_power)
		|=> flag_reg[1])
		else $error("Flag A cleared without a write.");

	a_trig_en_halt: assert property ((wr_sel[5] && wdata[match_timer_pkg::TC_TRIG_EN] && !trigger_en && !trig_evt &&
		!low_power) |=> !run_reg && trigger_en)
		else $error("Setting trigger_en did not stop the counter.");

	a_trig_ignored: assert property ((trigger_en && !run_reg && trig_edge == 2'h0 && !wr_sel[5] && !low_power)
		|=> !run_reg)
		else $error("Disabled trigger started the counter.");

	a_read_arms: assert property ((rd_sel[1] && flag_next[1])
		|=> armed_reg[1])
		else $error("Reading flag A as one did not arm its clear.");

	a_sync_single: assert property (pin_rise[2]
		|=> !pin_rise[2])
		else $error("One trigger edge gave two events.");

	a_write_count: assert property ((wr_sel[4] && !low_power)
		|=> cnt_reg == $past(wdata))
		else $error("Counter write did not land.");

	a_lowpower_flags: assert property (low_power
		|=> flag_reg == 3'h0 && !run_reg)
		else $error("Low power did not clear flags and run state.");

endmodule

`default_nettype wire

//--- hdl/match_timer_pkg.sv
// Purpose: Shared constants for the 8-bit compare-match timer.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes: Field positions and codes are used by the design; the bench takes only the register indices.
package match_timer_pkg;

	// Register word indices.
	localparam logic [15:0] IDX_CLOCK_CLEAR = 16'hffb8;
	localparam logic [15:0] IDX_FLAGS = 16'hffb9;
	localparam logic [15:0] IDX_CONST_A = 16'hffba;
	localparam logic [15:0] IDX_CONST_B = 16'hffbb;
	localparam logic [15:0] IDX_COUNTER = 16'hffbc;
	localparam logic [15:0] IDX_TRIGGER = 16'hffbd;

	// Reset values.
	localparam logic [7:0] RST_CLOCK_CLEAR = 8'h00;
	localparam logic [7:0] RST_FLAGS = 8'h10;
	localparam logic [7:0] RST_CONST = 8'hff;
	localparam logic [7:0] RST_COUNTER = 8'h00;
	localparam logic [7:0] RST_TRIGGER = 8'he2;

	// Bits that always read as one.
	localparam logic [7:0] FLAGS_RESERVED_MASK = 8'h10;
	localparam logic [7:0] TRIGGER_RESERVED_MASK = 8'he2;

	// Field positions in clock_clear_control.
	localparam int CC_MATCH_B_IE = 7;
	localparam int CC_MATCH_A_IE = 6;
	localparam int CC_OVF_IE = 5;
	localparam int CC_CLEAR_LO = 3;
	localparam int CC_CLK_LO = 0;

	// Field positions in flags_and_output_select.
	localparam int FL_MATCH_B = 7;
	localparam int FL_MATCH_A = 6;
	localparam int FL_OVF = 5;
	localparam int FL_OUT_B_LO = 2;
	localparam int FL_OUT_A_LO = 0;

	// Field positions in trigger_clock_control.
	localparam int TC_EDGE_LO = 3;
	localparam int TC_TRIG_EN = 2;
	localparam int TC_INT_CLK = 0;

	// Clear source codes.
	localparam logic [1:0] CLR_NONE = 2'h0;
	localparam logic [1:0] CLR_MATCH_A = 2'h1;
	localparam logic [1:0] CLR_MATCH_B = 2'h2;
	localparam logic [1:0] CLR_EXT = 2'h3;

	// Output actions on a compare match.
	localparam logic [1:0] ACT_KEEP = 2'h0;
	localparam logic [1:0] ACT_ZERO = 2'h1;
	localparam logic [1:0] ACT_ONE = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;

	// Smallest prescaler that reaches the slowest tap.
	localparam int MIN_PRESCALE_WIDTH = 7;

endpackage
